// >>> hdl/gdtc_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef GDTC_DEFS_SVH
`define GDTC_DEFS_SVH
// Register offsets (word index on the register port)
`define GDTC_OFF_ISR 3'h0
`define GDTC_OFF_BSR 3'h1
`define GDTC_OFF_CNT 3'h2
`define GDTC_OFF_ADR 3'h3
`define GDTC_OFF_BCR 3'h4
// Interface status fields
`define GDTC_ISR_GO 0
`define GDTC_ISR_HOLD 1
`define GDTC_ISR_DIN 2
`define GDTC_ISR_PACK 3
`define GDTC_ISR_BURST 4
`define GDTC_ISR_SWAP 5
`define GDTC_ISR_TIE 6
`define GDTC_ISR_DONE 7
`define GDTC_ISR_ABORT 8
`define GDTC_ISR_XFAULT 9
`define GDTC_ISR_ERR 10
`define GDTC_ISR_RENIE 11
// Bus status fields
`define GDTC_BSR_LRST 0
`define GDTC_BSR_INIT 1
`define GDTC_BSR_EIGN 2
// Bus control field
`define GDTC_BCR_ATND 0
// Reset values
`define GDTC_WORD_RST 16'h0000
`define GDTC_TMR_RST 10'h000
// Timing
`define GDTC_CLK_MHZ 25
`define GDTC_PART_TO_NS 20000
`define GDTC_PART_TO_CYC ((`GDTC_PART_TO_NS * `GDTC_CLK_MHZ) / 1000)
`define GDTC_SLV_TO_NS 2000
`define GDTC_SLV_TO_CYC ((`GDTC_SLV_TO_NS * `GDTC_CLK_MHZ) / 1000)
`endif

// >>> hdl/gdtc_pkg.sv
// Types of the transfer controller: states, state record, host bus carrier
package gdtc_pkg;
    // Gray coded along idle, wait, request, cycle, send
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAIT = 3'h1,
        ST_REQ = 3'h3,
        ST_CYC = 3'h2,
        ST_SEND = 3'h6
    } gdtc_state_type;

    // Whole module state
    typedef struct packed {
        gdtc_state_type st;
        logic go;
        logic hold;
        logic din;
        logic pack;
        logic burst;
        logic swap;
        logic tie;
        logic renie;
        logic done;
        logic abort;
        logic xfault;
        logic err;
        logic eign;
        logic atnd;
        logic lrst;
        logic own;
        logic eoi;
        logic [15:0] cnt;
        logic [15:0] addr;
        logic [15:0] rdata;
        logic [7:0] dbyte;
        logic [9:0] tmr;
    } gdtc_regs_type;

    // Host bus master outputs
    typedef struct packed {
        logic req;
        logic own;
        logic cyc;
        logic we;
        logic [1:0] be;
        logic [15:0] addr;
        logic [15:0] wdata;
    } gdtc_hbus_type;
endpackage

// >>> hdl/gdtc_top.sv
// Byte transfer controller between host memory and the instrument bus
// Contract
// - Run bit starts, clearing pauses, setting resumes
// - Hold-address keeps pointer fixed every byte
// - Direction set moves instrument bus to memory
// - Packed mode steps pointer by one byte
// - Unpacked receive writes zero high byte
// - Unpacked pointer steps two, lsb ignored
// - Cycle-steal mode releases bus after byte
// - Burst holds bus, drops after partner timeout
// - Swap reverses byte order within word in packed mode
// - Swap inverts pointer lsb, storage unchanged
// - Interrupt on done or error when enabled
// - Done on counter rollover or received EOI
// - Pointer and counter hold next-byte values
// - Abort on IFC, ATN, REN drop, faults
// - Abort clears run, sets abort and error
// - Pointer overflow or slave silence sets fault
// - Local reset reinitialises this block only
// - Init clears flags and run bit
// - End-ignore receive does not stop on EOI
// - EOI with last byte unless end-ignore
// - Attention drive suppresses EOI on last byte
// - Counter holds negated count, increments per byte
// - Strap sets count direction, hold overrides
`include "gdtc_defs.svh"

module gdtc_top #(
    parameter int PART_TO_CYC = `GDTC_PART_TO_CYC,
    parameter int SLV_TO_CYC = `GDTC_SLV_TO_CYC
) (
    input logic mclk,
    input logic sys_rst,
    input logic [2:0] reg_addr,
    input logic [15:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [15:0] reg_rdata,
    input logic count_direction_strap,
    input logic hb_gnt,
    input logic hb_ack,
    input logic [15:0] hb_rdata,
    output gdtc_pkg::gdtc_hbus_type hb_out,
    input logic rx_valid,
    input logic [7:0] rx_data,
    input logic rx_eoi,
    output logic rx_take,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_eoi,
    input logic tx_ready,
    input logic ifc,
    input logic atn_other,
    input logic remote_drop,
    input logic hs_fault,
    input logic wr_fault,
    output logic irq
);
    // Timer is ten bits wide, so longer timeouts cannot be counted
    if (PART_TO_CYC < 1 || PART_TO_CYC > 1023 || SLV_TO_CYC < 1 || SLV_TO_CYC > 1023)
    begin
        $error("timeout counts must lie in 1..1023");
    end

    localparam logic [9:0] PART_LAST = 10'(PART_TO_CYC - 1);
    localparam logic [9:0] SLV_LAST = 10'(SLV_TO_CYC - 1);

    gdtc_pkg::gdtc_regs_type s_r; // Registered state
    gdtc_pkg::gdtc_regs_type s_nxt; // Next state
    logic [16:0] step; // Pointer step, hold gives zero
    logic [16:0] addr_nx; // Next pointer, bit 16 is overflow
    logic [15:0] cnt_nx; // Next counter value
    logic fin; // Byte finished this cycle
    logic abrt; // Abort for pointer overflow or slave silence this cycle
    logic act; // Transfer running or paused mid-byte
    logic part_wait; // Owning bus, waiting on partner

    // Lsb swap used on the bus and on readback
    function automatic logic [15:0] eff_addr(input logic [15:0] a, input logic sw);
        eff_addr = {a[15:1], a[0] ^ sw};
    endfunction

    // Pointer step: none, one per byte, or two per word
    always_comb
    begin
        step = 17'h0_0002;
        if (s_r.hold)
        begin
            step = 17'h0_0000;
        end
        else if (s_r.pack)
        begin
            step = 17'h0_0001;
        end
        // Strap picks direction; carry or borrow flags overflow
        if (count_direction_strap)
        begin
            addr_nx = {1'b0, s_r.addr} - step;
        end
        else
        begin
            addr_nx = {1'b0, s_r.addr} + step;
        end
        cnt_nx = s_r.cnt + 16'h0001;
    end

    // Host bus drive
    always_comb
    begin
        hb_out.req = (s_r.st == gdtc_pkg::ST_REQ);
        hb_out.own = s_r.own;
        hb_out.cyc = (s_r.st == gdtc_pkg::ST_CYC);
        hb_out.we = s_r.din;
        // Packed: byte address with swap; else word address
        if (s_r.pack)
        begin
            hb_out.addr = eff_addr(s_r.addr, s_r.swap);
            hb_out.be = hb_out.addr[0] ? 2'h2 : 2'h1;
            hb_out.wdata = {s_r.dbyte, s_r.dbyte};
        end
        else
        begin
            hb_out.addr = {s_r.addr[15:1], 1'b0};
            hb_out.be = 2'h3;
            hb_out.wdata = {8'h00, s_r.dbyte};
        end
    end

    // Instrument side and interrupt
    assign tx_valid = (s_r.st == gdtc_pkg::ST_SEND);
    assign tx_data = s_r.dbyte;
    assign tx_eoi = s_r.eoi & tx_valid;
    assign reg_rdata = s_r.rdata;
    assign irq = s_r.tie & (s_r.done | s_r.err);
    assign act = s_r.go | (s_r.st != gdtc_pkg::ST_IDLE);
    assign part_wait = s_r.own & (((s_r.st == gdtc_pkg::ST_WAIT) & s_r.din & ~rx_valid)
        | ((s_r.st == gdtc_pkg::ST_SEND) & ~tx_ready));

    // Next state: register port, sequencer, byte end, abort
    always_comb
    begin
        s_nxt = s_r;
        rx_take = 1'b0;
        fin = 1'b0;
        abrt = 1'b0;
        s_nxt.rdata = `GDTC_WORD_RST;
        // Local reset restores everything in this block
        if (s_r.lrst)
        begin
            s_nxt = '0;
        end
        else
        begin
            // Read data stands one cycle only
            if (reg_rd)
            begin
                case (reg_addr)
                    `GDTC_OFF_ISR: s_nxt.rdata = {4'h0, s_r.renie, s_r.err, s_r.xfault,
                        s_r.abort, s_r.done, s_r.tie, s_r.swap, s_r.burst, s_r.pack,
                        s_r.din, s_r.hold, s_r.go};
                    `GDTC_OFF_BSR: s_nxt.rdata = {13'h0000, s_r.eign, 2'h0};
                    `GDTC_OFF_CNT: s_nxt.rdata = s_r.cnt;
                    `GDTC_OFF_ADR: s_nxt.rdata = eff_addr(s_r.addr, s_r.swap);
                    `GDTC_OFF_BCR: s_nxt.rdata = {15'h0000, s_r.atnd};
                    default: s_nxt.rdata = `GDTC_WORD_RST; // Unmapped reads zero
                endcase
            end
            // Software writes
            if (reg_wr)
            begin
                case (reg_addr)
                    `GDTC_OFF_ISR:
                    begin
                        s_nxt.go = reg_wdata[`GDTC_ISR_GO];
                        s_nxt.hold = reg_wdata[`GDTC_ISR_HOLD];
                        s_nxt.din = reg_wdata[`GDTC_ISR_DIN];
                        s_nxt.pack = reg_wdata[`GDTC_ISR_PACK];
                        s_nxt.burst = reg_wdata[`GDTC_ISR_BURST];
                        s_nxt.swap = reg_wdata[`GDTC_ISR_SWAP];
                        s_nxt.tie = reg_wdata[`GDTC_ISR_TIE];
                        s_nxt.renie = reg_wdata[`GDTC_ISR_RENIE];
                    end
                    `GDTC_OFF_BSR:
                    begin
                        s_nxt.lrst = reg_wdata[`GDTC_BSR_LRST];
                        s_nxt.eign = reg_wdata[`GDTC_BSR_EIGN];
                        // Init clears flags; hardware sets below win
                        if (reg_wdata[`GDTC_BSR_INIT])
                        begin
                            s_nxt.done = 1'b0;
                            s_nxt.abort = 1'b0;
                            s_nxt.xfault = 1'b0;
                            s_nxt.err = 1'b0;
                            s_nxt.go = 1'b0;
                        end
                    end
                    `GDTC_OFF_CNT: s_nxt.cnt = reg_wdata;
                    `GDTC_OFF_ADR: s_nxt.addr = reg_wdata;
                    `GDTC_OFF_BCR: s_nxt.atnd = reg_wdata[`GDTC_BCR_ATND];
                    default: s_nxt.lrst = 1'b0; // Unmapped writes ignored
                endcase
            end
            // Sequencer
            case (s_r.st)
                gdtc_pkg::ST_IDLE:
                begin
                    // Resume keeps pointer and counter as they stand
                    if (s_r.go)
                    begin
                        s_nxt.st = gdtc_pkg::ST_WAIT;
                        s_nxt.tmr = `GDTC_TMR_RST;
                    end
                end
                gdtc_pkg::ST_WAIT:
                begin
                    if (!s_r.go)
                    begin
                        s_nxt.st = gdtc_pkg::ST_IDLE;
                        s_nxt.own = 1'b0;
                    end
                    else if (s_r.din)
                    begin
                        // Receive: catch byte, then get the bus
                        if (rx_valid)
                        begin
                            rx_take = 1'b1;
                            s_nxt.dbyte = rx_data;
                            s_nxt.eoi = rx_eoi;
                            s_nxt.tmr = `GDTC_TMR_RST;
                            s_nxt.st = s_r.own ? gdtc_pkg::ST_CYC : gdtc_pkg::ST_REQ;
                        end
                    end
                    else
                    begin
                        // Send: fetch from memory first
                        s_nxt.tmr = `GDTC_TMR_RST;
                        s_nxt.st = s_r.own ? gdtc_pkg::ST_CYC : gdtc_pkg::ST_REQ;
                    end
                end
                gdtc_pkg::ST_REQ:
                begin
                    // Wait for grant before any memory cycle
                    if (hb_gnt)
                    begin
                        s_nxt.own = 1'b1;
                        s_nxt.tmr = `GDTC_TMR_RST;
                        s_nxt.st = gdtc_pkg::ST_CYC;
                    end
                end
                gdtc_pkg::ST_CYC:
                begin
                    if (hb_ack)
                    begin
                        s_nxt.tmr = `GDTC_TMR_RST;
                        if (s_r.din)
                        begin
                            fin = 1'b1;
                        end
                        else
                        begin
                            // Pick lane; unpacked uses low byte only
                            if (s_r.pack && hb_out.addr[0])
                            begin
                                s_nxt.dbyte = hb_rdata[15:8];
                            end
                            else
                            begin
                                s_nxt.dbyte = hb_rdata[7:0];
                            end
                            // Last byte carries EOI unless suppressed
                            s_nxt.eoi = (s_r.cnt == 16'hffff) & ~s_r.eign & ~s_r.atnd;
                            s_nxt.st = gdtc_pkg::ST_SEND;
                            // One byte per grant when not in burst
                            if (!s_r.burst)
                            begin
                                s_nxt.own = 1'b0;
                            end
                        end
                    end
                    else if (s_r.tmr == SLV_LAST)
                    begin
                        s_nxt.xfault = 1'b1;
                        abrt = 1'b1;
                    end
                    else
                    begin
                        s_nxt.tmr = s_r.tmr + 10'h001;
                    end
                end
                gdtc_pkg::ST_SEND:
                begin
                    if (tx_ready)
                    begin
                        fin = 1'b1;
                    end
                end
                default: s_nxt.st = gdtc_pkg::ST_IDLE;
            endcase
            // Slow partner: drop the bus, no error, rerequest later
            if (part_wait)
            begin
                if (s_r.tmr == PART_LAST)
                begin
                    s_nxt.own = 1'b0;
                    s_nxt.tmr = `GDTC_TMR_RST;
                end
                else
                begin
                    s_nxt.tmr = s_r.tmr + 10'h001;
                end
            end
            // Byte finished: count, step, decide end
            if (fin)
            begin
                s_nxt.cnt = cnt_nx;
                s_nxt.addr = addr_nx[15:0];
                if (addr_nx[16])
                begin
                    s_nxt.xfault = 1'b1;
                    abrt = 1'b1;
                end
                else if (cnt_nx == 16'h0000 || (s_r.din && s_r.eoi && !s_r.eign))
                begin
                    s_nxt.done = 1'b1;
                    s_nxt.go = 1'b0;
                    s_nxt.own = 1'b0;
                    s_nxt.st = gdtc_pkg::ST_IDLE;
                end
                else
                begin
                    s_nxt.st = s_r.go ? gdtc_pkg::ST_WAIT : gdtc_pkg::ST_IDLE;
                    if (!s_r.burst || !s_r.go)
                    begin
                        s_nxt.own = 1'b0;
                    end
                end
            end
            // Faults flag the summary error at once
            if (hs_fault || wr_fault)
            begin
                s_nxt.err = 1'b1;
            end
            // Abort of a running transfer; error may already be set
            if (abrt || (act && (ifc || atn_other || (remote_drop && s_r.renie)
                || hs_fault || wr_fault)))
            begin
                s_nxt.go = 1'b0;
                s_nxt.abort = 1'b1;
                s_nxt.err = 1'b1;
                s_nxt.own = 1'b0;
                s_nxt.st = gdtc_pkg::ST_IDLE;
            end
        end
    end

    // Single state register, synchronous reset
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst || s_r.lrst);

    localparam int SLV_BND = SLV_TO_CYC;

    sequence seq_byte_end;
        fin && !addr_nx[16] && cnt_nx == 16'h0000 && !abrt;
    endsequence

    sequence seq_mem_cycle;
        hb_out.cyc ##1 !hb_out.cyc;
    endsequence

    chk_go_start: assert property (s_r.go && s_r.st == gdtc_pkg::ST_IDLE && !ifc
        && !atn_other && !(remote_drop && s_r.renie) && !hs_fault && !wr_fault
        |=> s_r.st == gdtc_pkg::ST_WAIT) else $error("run bit did not start");
    chk_hold_addr: assert property (fin && s_r.hold && !reg_wr
        |=> $stable(s_r.addr)) else $error("pointer moved under hold");
    chk_dir_write: assert property (rx_take && !reg_wr
        |=> hb_out.we && s_r.dbyte == $past(rx_data))
        else $error("received byte not routed to memory");
    chk_unpack_zero: assert property (hb_out.cyc && s_r.din && !s_r.pack
        |-> hb_out.wdata[15:8] == 8'h00 && hb_out.be == 2'h3)
        else $error("high byte not cleared");
    chk_step_two: assert property (fin && !s_r.pack && !s_r.hold && !count_direction_strap
        && !addr_nx[16] && !reg_wr |=> s_r.addr == $past(s_r.addr) + 16'h0002)
        else $error("pointer step not two");
    chk_cyc_release: assert property (fin && !s_r.burst |=> !s_r.own)
        else $error("bus kept after byte");
    chk_part_drop: assert property (part_wait && s_r.tmr == PART_LAST |=> !s_r.own && !s_r.err)
        else $error("partner timeout mishandled");
    chk_swap_lsb: assert property (hb_out.cyc && s_r.pack
        |-> hb_out.addr[0] == (s_r.addr[0] ^ s_r.swap)) else $error("swap lsb wrong");
    chk_irq_level: assert property ((s_r.tie && !reg_wr) ##0 seq_byte_end |=> irq)
        else $error("interrupt missing");
    chk_done_stop: assert property (seq_byte_end |=> s_r.done && !s_r.go
        && s_r.st == gdtc_pkg::ST_IDLE) else $error("rollover did not end");
    chk_abort_flags: assert property (act && ifc |=> s_r.abort && s_r.err && !s_r.go
        && !s_r.own) else $error("abort flags wrong");
    chk_slave_bound: assert property ($rose(hb_out.cyc)
        |-> seq_mem_cycle or ##[1:SLV_BND] !hb_out.cyc)
        else $error("memory cycle never ended");
    chk_eoi_atn: assert property (tx_valid && s_r.atnd |-> !tx_eoi)
        else $error("EOI sent under attention");
endmodule

// >>> verif/gdtc_far_model.sv
// Far side model: host memory slave with arbiter, instrument talker and listener
module gdtc_far_model (
    input wire logic mclk,
    input wire gdtc_pkg::gdtc_hbus_type hb_out,
    input wire logic ack_en,
    input wire logic restart,
    input wire logic [7:0] rx_n,
    input wire logic [7:0] rx_eoi_at,
    input wire logic rx_take,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_eoi,
    output logic hb_gnt,
    output logic hb_ack,
    output logic [15:0] hb_rdata,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_eoi,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:31]; // Word memory, filled by the bench
    logic [7:0] idx_r = 8'h00; // Next byte offered
    logic tick_r = 1'b0; // Alternates fast and slow answers
    logic [7:0] tx_log [0:15]; // Bytes taken from the block
    logic [7:0] tx_cnt_r = 8'h00;
    logic tx_last_eoi_r = 1'b0;
    logic ack_r = 1'b0;
    // Grant follows the request, nothing is owned unasked
    assign hb_gnt = hb_out.req;
    assign hb_ack = ack_r;
    // Idle read lines toggle so a stale sample cannot pass
    assign hb_rdata = ack_r ? mem[hb_out.addr[5:1]] : (16'h5a5a ^ {16{tick_r}});
    assign rx_valid = idx_r < rx_n;
    assign rx_data = 8'h41 + idx_r;
    assign rx_eoi = rx_valid && (idx_r == rx_eoi_at);
    // Listener stalls every other cycle
    assign tx_ready = tick_r;
    // Memory answers one or two cycles into a cycle, or never
    always @(posedge mclk)
    begin
        tick_r <= ~tick_r;
        ack_r <= hb_out.cyc && !ack_r && ack_en && tick_r;
        if (ack_r && hb_out.we && hb_out.be[0])
            mem[hb_out.addr[5:1]][7:0] <= hb_out.wdata[7:0];
        if (ack_r && hb_out.we && hb_out.be[1])
            mem[hb_out.addr[5:1]][15:8] <= hb_out.wdata[15:8];
        if (restart)
        begin
            idx_r <= 8'h00;
            tx_cnt_r <= 8'h00;
        end
        else
        begin
            if (rx_take)
                idx_r <= idx_r + 8'h01;
            if (tx_valid && tx_ready)
            begin
                tx_log[tx_cnt_r[3:0]] <= tx_data;
                tx_cnt_r <= tx_cnt_r + 8'h01;
                tx_last_eoi_r <= tx_eoi;
            end
        end
    end
endmodule

// >>> verif/gpib_dma_transfer_control_tb_top.sv
// Self-checking bench for the byte transfer controller
`include "gdtc_defs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module gpib_dma_transfer_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic strap = 1'b0;
    logic [4:0] cause = 5'h00; // Abort causes, one bit each
    logic ack_en = 1'b1;
    logic restart = 1'b0;
    logic [7:0] rx_n = 8'h00;
    logic [7:0] rx_eoi_at = 8'hff;
    logic [15:0] reg_rdata, hb_rdata, q;
    logic [7:0] rx_data, tx_data;
    logic hb_gnt, hb_ack, rx_valid, rx_eoi, rx_take, tx_valid, tx_eoi, tx_ready, irq, own_d;
    gdtc_pkg::gdtc_hbus_type hb_out;
    int errors = 0;
    int total_checks = 0;
    int owns = 0; // Bus acquisitions since launch
    always #20 mclk = ~mclk;
    // Short timeouts keep the run brief
    gdtc_top #(.PART_TO_CYC(8), .SLV_TO_CYC(4)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .count_direction_strap(strap), .hb_gnt(hb_gnt),
        .hb_ack(hb_ack), .hb_rdata(hb_rdata), .hb_out(hb_out), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_take(rx_take), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_ready(tx_ready), .ifc(cause[0]),
        .atn_other(cause[1]), .remote_drop(cause[2]), .hs_fault(cause[3]),
        .wr_fault(cause[4]), .irq(irq));
    gdtc_far_model u_far (.mclk(mclk), .hb_out(hb_out), .ack_en(ack_en), .restart(restart),
        .rx_n(rx_n), .rx_eoi_at(rx_eoi_at), .rx_take(rx_take), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_eoi(tx_eoi), .hb_gnt(hb_gnt), .hb_ack(hb_ack),
        .hb_rdata(hb_rdata), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eoi(rx_eoi),
        .tx_ready(tx_ready));
    // Count bus acquisitions
    always @(posedge mclk)
    begin
        own_d <= hb_out.own;
        if (hb_out.own && !own_d)
            owns++;
    end
    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    // Poll status until a flag shows, bounded
    task automatic wait_isr(input logic [15:0] m);
        int i;
        for (i = 0; i < 400; i++)
        begin
            rd(`GDTC_OFF_ISR);
            if ((q & m) !== 16'h0000)
                break;
        end
        if (i == 400)
        begin
            errors++;
            results();
        end
    endtask
    // Init, counter, pointer, far side, then mode and run
    task automatic launch(input logic [15:0] cnt, input logic [15:0] adr, input logic [7:0] n,
        input logic [7:0] eoi_at, input logic [15:0] bus_status, input logic [15:0] interface_status);
        wr(`GDTC_OFF_BSR, bus_status | 16'h0002);
        wr(`GDTC_OFF_CNT, cnt);
        wr(`GDTC_OFF_ADR, adr);
        @(posedge mclk);
        rx_n <= n;
        rx_eoi_at <= eoi_at;
        restart <= 1'b1;
        owns = 0;
        @(posedge mclk);
        restart <= 1'b0;
        wr(`GDTC_OFF_ISR, interface_status);
    endtask
    task automatic s_regs();
        for (int a = 0; a < 8; a++)
        begin
            rd(a[2:0]);
            `CHK(q, 16'h0000)
        end
        wr(`GDTC_OFF_ISR, 16'h0846);
        rd(`GDTC_OFF_ISR);
        `CHK(q, 16'h0846)
        wr(`GDTC_OFF_BSR, 16'h0001);
        @(posedge mclk);
        rd(`GDTC_OFF_ISR);
        `CHK(q, 16'h0000)
    endtask
    // Unpacked cycle-steal receive, counting up
    task automatic s_rx_unpacked();
        launch(16'hfffd, 16'h0010, 8'h03, 8'hff, 16'h0000, 16'h0045);
        wait_isr(16'h0080);
        for (int i = 0; i < 3; i++)
            `CHK(u_far.mem[8 + i], 16'h0041 + i[15:0])
        `CHK(owns, 3)
        `CHK(irq, 1'b1)
        rd(`GDTC_OFF_CNT);
        `CHK(q, 16'h0000)
        rd(`GDTC_OFF_ADR);
        `CHK(q, 16'h0016)
    endtask
    // Packed swapped burst send, high byte first
    task automatic s_tx_swap();
        launch(16'hfffc, 16'h0020, 8'h00, 8'hff, 16'h0000, 16'h0039);
        wait_isr(16'h0080);
        rd(`GDTC_OFF_ADR);
        `CHK(q, 16'h0025)
        `CHK(owns, 1)
        `CHK(u_far.tx_cnt_r, 8'h04)
        for (int i = 0; i < 4; i++)
            `CHK(u_far.tx_log[i], 8'h41 + i[7:0])
        `CHK(u_far.tx_last_eoi_r, 1'b1)
    endtask
    // Final byte without end flag: attention drive, then end-ignore
    task automatic s_tx_noeoi();
        for (int k = 0; k < 2; k++)
        begin
            wr(`GDTC_OFF_BCR, (k == 0) ? 16'h0001 : 16'h0000);
            launch(16'hffff, 16'h0020, 8'h00, 8'hff, (k == 0) ? 16'h0000 : 16'h0004, 16'h0001);
            wait_isr(16'h0080);
            `CHK(u_far.tx_log[0], 8'h42)
            `CHK(u_far.tx_last_eoi_r, 1'b0)
        end
    endtask
    // Packed receive counting down from odd address, end flag honoured then ignored
    task automatic s_rx_down();
        strap <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            launch(16'hfffc, 16'h0031, 8'h04, 8'h01, (k == 0) ? 16'h0000 : 16'h0004, 16'h000d);
            wait_isr(16'h0080);
            `CHK(u_far.mem[24], 16'h4142)
            rd(`GDTC_OFF_CNT);
            `CHK(q, (k == 0) ? 16'hfffe : 16'h0000)
            rd(`GDTC_OFF_ADR);
            `CHK(q, (k == 0) ? 16'h002f : 16'h002d)
        end
        `CHK(u_far.mem[23], 16'h4344)
        launch(16'hfffe, 16'h003a, 8'h02, 8'hff, 16'h0000, 16'h0007);
        wait_isr(16'h0080);
        `CHK(u_far.mem[29], 16'h0042)
        rd(`GDTC_OFF_ADR);
        `CHK(q, 16'h003a)
        strap <= 1'b0;
    endtask
    // Burst receive stalls past the partner timeout, then resumes
    task automatic s_stall();
        launch(16'hfffe, 16'h0014, 8'h01, 8'hff, 16'h0000, 16'h0015);
        repeat (20) @(posedge mclk);
        `CHK(hb_out.own, 1'b0)
        rd(`GDTC_OFF_ISR);
        `CHK(q & 16'h0481, 16'h0001)
        @(posedge mclk);
        rx_n <= 8'h02;
        wait_isr(16'h0080);
        `CHK(q & 16'h0400, 16'h0000)
        `CHK(owns, 2)
        `CHK(u_far.mem[11], 16'h0042)
    endtask
    // Each abort cause in turn, then init clears
    task automatic s_abort();
        for (int i = 0; i < 5; i++)
        begin
            launch(16'hfff0, 16'h0010, 8'h00, 8'hff, 16'h0000, 16'h0845);
            @(posedge mclk);
            cause <= 5'h01 << i;
            @(posedge mclk);
            cause <= 5'h00;
            wait_isr(16'h0100);
            `CHK(q & 16'h0501, 16'h0500)
        end
        wr(`GDTC_OFF_BSR, 16'h0002);
        rd(`GDTC_OFF_ISR);
        `CHK(q & 16'h0781, 16'h0000)
    endtask
    // Silent memory slave
    task automatic s_slave();
        ack_en <= 1'b0;
        launch(16'hfff0, 16'h0010, 8'h00, 8'hff, 16'h0000, 16'h0041);
        wait_isr(16'h0200);
        `CHK(irq, 1'b1)
        ack_en <= 1'b1;
        wr(`GDTC_OFF_BSR, 16'h0002);
        rd(`GDTC_OFF_ISR);
        `CHK(q & 16'h0200, 16'h0000)
    endtask
    initial
    begin
        for (int i = 0; i < 32; i++)
            u_far.mem[i] = 16'hffff;
        u_far.mem[16] = 16'h4142;
        u_far.mem[17] = 16'h4344;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        s_regs();
        s_rx_unpacked();
        s_tx_swap();
        s_tx_noeoi();
        s_rx_down();
        s_stall();
        s_abort();
        s_slave();
        results();
    end
endmodule
